// ==== sp0c_ctrl.v ====
// Serial port 0 control register, transmitter and receiver.
// Assumes baud_tick is a 16x oversample strobe on mclk and that the
// SFR port and option inputs come from logic on mclk.
`timescale 1ns/1ps
`include "sp0c_defs.vh"
`default_nettype none
module sp0c_ctrl
(
   input wire mclk,
   input wire rst,
   input wire [7:0] sfr_addr,
   input wire sfr_wr_en,
   input wire [7:0] sfr_wdata,
   input wire sfr_rd_en,
   output reg [7:0] sfr_rdata_r,
   input wire [7:0] sfr_bit_addr,
   input wire sfr_bit_wr_en,
   input wire sfr_bit_wdata,
   input wire frame_err_access_option,
   input wire serial_int_enable,
   output reg serial_irq_r,
   input wire baud_tick,
   input wire [7:0] given_addr,
   input wire [7:0] broadcast_addr,
   input wire [7:0] tx_data,
   input wire tx_valid,
   output wire tx_ready,
   output reg [7:0] rx_data_r,
   output reg rx_valid_r,
   input wire rxd_in,
   output reg rxd_out_r,
   output reg rxd_oe_r,
   output reg txd_r
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_M0 = 2'h1;
   localparam [1:0] ST_ASYNC = 2'h2;

   reg mode_hi_r;
   reg frame_error_flag_r;
   reg mode_sel_lo_r;
   reg multiproc_filter_enable_r;
   reg rx_enable_r;
   reg ninth_tx_bit_r;
   reg ninth_rx_bit_r;
   reg tx_done_flag_r;
   reg rx_done_flag_r;
   reg [7:0] wmask;
   reg [7:0] wval;
   reg ti_set_r;
   reg ri_set_r;
   reg fe_set_r;
   reg rb8_set_r;
   reg rb8_val_r;
   reg rxd_s1_r;
   reg rxd_s2_r;
   reg rxd_prev_r;
   reg [1:0] tx_st_r;
   reg m0_rx_r;
   reg m0_phase_r;
   reg [3:0] tx_bitn_r;
   reg [3:0] tx_ovs_r;
   reg [10:0] tx_sh_r;
   reg [1:0] rx_st_r;
   reg [3:0] rx_bitn_r;
   reg [3:0] rx_ovs_r;
   reg [8:0] rx_sh_r;
   wire [1:0] mode;
   wire [7:0] ctrl_rd;
   wire [7:0] fifo_data;
   wire fifo_valid;
   wire fifo_pop;
   wire m0_tick;
   wire [3:0] frame_len;
   wire m0_rx_start;
   wire [7:0] rx_byte;
   wire rx_accept;

   function bit_hit;
      input [7:0] baddr;
      input [2:0] idx;
      begin
         bit_hit = (baddr == (`SP0C_CTRL_ADDR | {5'h00, idx}));
      end
   endfunction

   function addr_match;
      input [7:0] d;
      input [7:0] g;
      input [7:0] b;
      begin
         addr_match = (d == g) || (d == b);
      end
   endfunction

   assign mode = {mode_hi_r, mode_sel_lo_r};
   assign frame_len = mode[1] ? `SP0C_FRAME_M23 : `SP0C_FRAME_M1;
   assign ctrl_rd = {frame_err_access_option ? frame_error_flag_r
                     : mode_hi_r, mode_sel_lo_r,
                     multiproc_filter_enable_r, rx_enable_r,
                     ninth_tx_bit_r, ninth_rx_bit_r,
                     tx_done_flag_r, rx_done_flag_r};

   sp0c_fifo #(
      .W(`SP0C_FIFO_W),
      .D(`SP0C_FIFO_D)
   )
   u_fifo
   (
      .mclk(mclk),
      .rst(rst),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready_r(tx_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   sp0c_shclk u_shclk
   (
      .mclk(mclk),
      .rst(rst),
      .run(tx_st_r == ST_M0),
      .fast(multiproc_filter_enable_r),
      .tick_r(m0_tick)
   );

   // Byte write at the control address, or single-bit write at that address plus the bit index
   always @*
   begin
      wmask = 8'h00;
      wval = 8'h00;
      if (sfr_wr_en && sfr_addr == `SP0C_CTRL_ADDR)
      begin
         wmask = 8'hFF;
         wval = sfr_wdata;
      end
      else if (sfr_bit_wr_en &&
               bit_hit(sfr_bit_addr, sfr_bit_addr[2:0]))
      begin
         wmask = 8'h01 << sfr_bit_addr[2:0];
         wval = {8{sfr_bit_wdata}};
      end
   end

   // Hardware sets take priority over a software write in the same cycle
   always @(posedge mclk)
   begin
      if (rst)
      begin
         mode_hi_r <= 1'b0;
         frame_error_flag_r <= 1'b0;
         mode_sel_lo_r <= 1'b0;
         multiproc_filter_enable_r <= 1'b0;
         rx_enable_r <= 1'b0;
         ninth_tx_bit_r <= 1'b0;
         ninth_rx_bit_r <= 1'b0;
         tx_done_flag_r <= 1'b0;
         rx_done_flag_r <= 1'b0;
         sfr_rdata_r <= `SP0C_CTRL_RST;
         serial_irq_r <= 1'b0;
      end
      else
      begin
         if (wmask[`SP0C_BIT_MODE_HI] && !frame_err_access_option)
            mode_hi_r <= wval[`SP0C_BIT_MODE_HI];
         if (fe_set_r)
            frame_error_flag_r <= 1'b1;
         else if (wmask[`SP0C_BIT_MODE_HI] && frame_err_access_option)
            frame_error_flag_r <= wval[`SP0C_BIT_MODE_HI];
         if (wmask[`SP0C_BIT_MODE_LO])
            mode_sel_lo_r <= wval[`SP0C_BIT_MODE_LO];
         if (wmask[`SP0C_BIT_MPF])
            multiproc_filter_enable_r <= wval[`SP0C_BIT_MPF];
         if (wmask[`SP0C_BIT_REN])
            rx_enable_r <= wval[`SP0C_BIT_REN];
         if (wmask[`SP0C_BIT_TB8])
            ninth_tx_bit_r <= wval[`SP0C_BIT_TB8];
         if (rb8_set_r)
            ninth_rx_bit_r <= rb8_val_r;
         else if (wmask[`SP0C_BIT_RB8])
            ninth_rx_bit_r <= wval[`SP0C_BIT_RB8];
         if (ti_set_r)
            tx_done_flag_r <= 1'b1;
         else if (wmask[`SP0C_BIT_TI])
            tx_done_flag_r <= wval[`SP0C_BIT_TI];
         if (ri_set_r)
            rx_done_flag_r <= 1'b1;
         else if (wmask[`SP0C_BIT_RI])
            rx_done_flag_r <= wval[`SP0C_BIT_RI];
         if (sfr_rd_en)
            sfr_rdata_r <= (sfr_addr == `SP0C_CTRL_ADDR) ? ctrl_rd : 8'h00;
         serial_irq_r <= serial_int_enable &&
                         (tx_done_flag_r || rx_done_flag_r);
      end
   end

   always @(posedge mclk)
   begin
      if (rst)
      begin
         rxd_s1_r <= 1'b1;
         rxd_s2_r <= 1'b1;
         rxd_prev_r <= 1'b1;
      end
      else
      begin
         rxd_s1_r <= rxd_in;
         rxd_s2_r <= rxd_s1_r;
         rxd_prev_r <= rxd_s2_r;
      end
   end

   // Mode 0 receive waits one extra cycle while the flag set is in flight
   assign m0_rx_start = (mode == 2'h0) && rx_enable_r &&
                        !rx_done_flag_r && !ri_set_r;
   assign fifo_pop = (tx_st_r == ST_IDLE) && fifo_valid &&
                     (rx_st_r == ST_IDLE || mode != 2'h0);

   // Transmit engine; also carries the mode 0 shift sequence both ways
   always @(posedge mclk)
   begin
      if (rst)
      begin
         tx_st_r <= ST_IDLE;
         m0_rx_r <= 1'b0;
         m0_phase_r <= 1'b0;
         tx_bitn_r <= 4'h0;
         tx_ovs_r <= 4'h0;
         tx_sh_r <= 11'h7FF;
         txd_r <= 1'b1;
         rxd_out_r <= 1'b1;
         rxd_oe_r <= 1'b0;
         ti_set_r <= 1'b0;
      end
      else
      begin
         ti_set_r <= 1'b0;
         case (tx_st_r)
            ST_IDLE:
            begin
               tx_bitn_r <= 4'h0;
               tx_ovs_r <= 4'h0;
               m0_phase_r <= 1'b0;
               if (fifo_pop && mode == 2'h0)
               begin
                  tx_st_r <= ST_M0;
                  m0_rx_r <= 1'b0;
                  tx_sh_r <= {3'h7, fifo_data};
                  rxd_oe_r <= 1'b1;
               end
               else if (fifo_pop)
               begin
                  tx_st_r <= ST_ASYNC;
                  // Ninth bit only rides in modes 2 and 3
                  tx_sh_r <= mode[1] ? {1'b1, ninth_tx_bit_r, fifo_data,
                     1'b0} : {2'h3, fifo_data, 1'b0};
                  txd_r <= 1'b0;
               end
               else if (m0_rx_start && rx_st_r == ST_IDLE)
               begin
                  tx_st_r <= ST_M0;
                  m0_rx_r <= 1'b1;
                  rxd_oe_r <= 1'b0;
               end
            end
            ST_M0:
            begin
               if (m0_tick && !m0_phase_r)
               begin
                  txd_r <= 1'b0;
                  rxd_out_r <= tx_sh_r[0];
                  m0_phase_r <= 1'b1;
               end
               else if (m0_tick)
               begin
                  txd_r <= 1'b1;
                  m0_phase_r <= 1'b0;
                  tx_sh_r <= {2'h3, rxd_s2_r, tx_sh_r[8:1]};
                  tx_bitn_r <= tx_bitn_r + 4'h1;
                  if (tx_bitn_r == `SP0C_M0_BITS - 4'h1)
                  begin
                     tx_st_r <= ST_IDLE;
                     rxd_oe_r <= 1'b0;
                     rxd_out_r <= 1'b1;
                     ti_set_r <= !m0_rx_r;
                  end
               end
            end
            ST_ASYNC:
            begin
               if (baud_tick)
               begin
                  tx_ovs_r <= tx_ovs_r + 4'h1;
                  if (tx_ovs_r == `SP0C_OVS_LAST)
                  begin
                     tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                     txd_r <= tx_sh_r[1];
                     tx_bitn_r <= tx_bitn_r + 4'h1;
                     // Flag rises as the stop bit begins
                     if (tx_bitn_r == frame_len - 4'h2)
                        ti_set_r <= 1'b1;
                     if (tx_bitn_r == frame_len - 4'h1)
                        tx_st_r <= ST_IDLE;
                  end
               end
            end
            default:
               tx_st_r <= ST_IDLE;
         endcase
      end
   end

   // Mode 0 receive completes in the transmit engine above
   always @(posedge mclk)
   begin
      if (rst)
      begin
         rx_data_r <= 8'h00;
         rx_valid_r <= 1'b0;
      end
      else if (tx_st_r == ST_M0 && m0_rx_r && m0_tick && m0_phase_r &&
               tx_bitn_r == `SP0C_M0_BITS - 4'h1)
      begin
         rx_data_r <= {rxd_s2_r, tx_sh_r[8:2]};
         rx_valid_r <= 1'b1;
      end
      else if (rx_st_r == ST_ASYNC && rx_accept)
      begin
         rx_data_r <= rx_byte;
         rx_valid_r <= 1'b1;
      end
      else
         rx_valid_r <= 1'b0;
   end

   assign rx_byte = mode[1] ? rx_sh_r[7:0] : rx_sh_r[8:1];
   // Accept is only meaningful on the stop-bit sample
   assign rx_accept = baud_tick && rx_ovs_r == `SP0C_OVS_MID &&
      rx_bitn_r == frame_len - 4'h1 &&
      (!multiproc_filter_enable_r ||
       ((mode[1] ? rx_sh_r[8] : rxd_s2_r) &&
        addr_match(rx_byte, given_addr, broadcast_addr)));

   // Asynchronous receive for modes 1 to 3
   always @(posedge mclk)
   begin
      if (rst)
      begin
         rx_st_r <= ST_IDLE;
         rx_bitn_r <= 4'h0;
         rx_ovs_r <= 4'h0;
         rx_sh_r <= 9'h000;
         ri_set_r <= 1'b0;
         fe_set_r <= 1'b0;
         rb8_set_r <= 1'b0;
         rb8_val_r <= 1'b0;
      end
      else
      begin
         ri_set_r <= (tx_st_r == ST_M0) && m0_rx_r && m0_tick &&
            m0_phase_r && tx_bitn_r == `SP0C_M0_BITS - 4'h1;
         fe_set_r <= 1'b0;
         rb8_set_r <= 1'b0;
         case (rx_st_r)
            ST_IDLE:
            begin
               rx_bitn_r <= 4'h0;
               rx_ovs_r <= 4'h0;
               if (mode != 2'h0 && rx_enable_r && rxd_prev_r &&
                   !rxd_s2_r)
                  rx_st_r <= ST_ASYNC;
            end
            ST_ASYNC:
            begin
               if (!rx_enable_r || mode == 2'h0)
                  rx_st_r <= ST_IDLE;
               else if (baud_tick)
               begin
                  rx_ovs_r <= rx_ovs_r + 4'h1;
                  if (rx_ovs_r == `SP0C_OVS_MID)
                  begin
                     rx_bitn_r <= rx_bitn_r + 4'h1;
                     if (rx_bitn_r == 4'h0)
                     begin
                        // A glitch shorter than half a bit is dropped
                        if (rxd_s2_r)
                           rx_st_r <= ST_IDLE;
                     end
                     else if (rx_bitn_r == frame_len - 4'h1)
                     begin
                        rx_st_r <= ST_IDLE;
                        fe_set_r <= !rxd_s2_r;
                        ri_set_r <= rx_accept;
                        rb8_set_r <= rx_accept;
                        rb8_val_r <= mode[1] ? rx_sh_r[8] : rxd_s2_r;
                     end
                     else
                        rx_sh_r <= {rxd_s2_r, rx_sh_r[8:1]};
                  end
               end
            end
            default:
               rx_st_r <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== sp0c_ctrl_chk.sv ====
// Port-level checks for the serial port 0 control block.
// Assumes it is bound to sp0c_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sp0c_ctrl_chk
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr_en,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd_en,
   input wire logic [7:0] sfr_rdata_r,
   input wire logic sfr_bit_wr_en,
   input wire logic frame_err_access_option,
   input wire logic serial_int_enable,
   input wire logic serial_irq_r,
   input wire logic rx_valid_r,
   input wire logic txd_r,
   input wire logic rxd_oe_r
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   a_reset_values: assert property ($past(rst) |->
      sfr_rdata_r == 8'h00 && !serial_irq_r && txd_r && !rxd_oe_r)
      else $error("outputs wrong after reset");
   a_unmapped_read: assert property (
      sfr_rd_en && sfr_addr != 8'h98 |=> sfr_rdata_r == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_readback: assert property (
      (sfr_wr_en && sfr_addr == 8'h98 && !frame_err_access_option)
      ##1 (!sfr_wr_en && !sfr_bit_wr_en) ##1 (sfr_rd_en && !sfr_wr_en
      && !sfr_bit_wr_en && sfr_addr == 8'h98 && !frame_err_access_option)
      |=> sfr_rdata_r[7:3] == $past(sfr_wdata[7:3], 3))
      else $error("control bits not read back");
   a_irq_masked: assert property (!serial_int_enable |=> !serial_irq_r)
      else $error("request while disabled");
   a_irq_on_rx: assert property (rx_valid_r && serial_int_enable |->
      ##[0:3] (serial_irq_r || !serial_int_enable))
      else $error("no request after receive");
   a_rx_pulse: assert property (rx_valid_r |=> !rx_valid_r)
      else $error("receive strobe too long");
   // Frame bits are at least 16 ticks low, so 8 low cycles marks them
   a_shift_half: assert property ($fell(txd_r) |-> (!txd_r ##1 txd_r)
      or (!txd_r [*6] ##1 txd_r) or (!txd_r [*8]))
      else $error("shift clock low phase wrong");
   a_rdata_hold: assert property (!sfr_rd_en |=> $stable(sfr_rdata_r))
      else $error("read data moved without read");
   c_rx: cover property (rx_valid_r);
   c_irq: cover property ($rose(serial_irq_r));
   c_fast: cover property ($fell(txd_r) ##1 txd_r);
endmodule
bind sp0c_ctrl sp0c_ctrl_chk u_sp0c_ctrl_chk (.mclk(mclk), .rst(rst),
   .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata),
   .sfr_rd_en(sfr_rd_en), .sfr_rdata_r(sfr_rdata_r),
   .sfr_bit_wr_en(sfr_bit_wr_en),
   .frame_err_access_option(frame_err_access_option),
   .serial_int_enable(serial_int_enable), .serial_irq_r(serial_irq_r),
   .rx_valid_r(rx_valid_r), .txd_r(txd_r), .rxd_oe_r(rxd_oe_r));
`default_nettype wire

// ==== sp0c_defs.vh ====
// Constants for the serial port 0 control block: register address,
// bit positions, reset value and shift timing.
// Assumes inclusion by every design file of the block except the FIFO.
`ifndef SP0C_DEFS_VH
`define SP0C_DEFS_VH

`define SP0C_CTRL_ADDR 8'h98
`define SP0C_CTRL_RST 8'h00
`define SP0C_BIT_MODE_HI 7
`define SP0C_BIT_MODE_LO 6
`define SP0C_BIT_MPF 5
`define SP0C_BIT_REN 4
`define SP0C_BIT_TB8 3
`define SP0C_BIT_RB8 2
`define SP0C_BIT_TI 1
`define SP0C_BIT_RI 0

`define SP0C_DIV_STD 12
`define SP0C_DIV_FAST 2
`define SP0C_HALF_STD 3'h5
`define SP0C_HALF_FAST 3'h0
`define SP0C_OVS_LAST 4'hF
`define SP0C_OVS_MID 4'h7
`define SP0C_M0_BITS 4'h8
`define SP0C_FRAME_M1 4'hA
`define SP0C_FRAME_M23 4'hB
`define SP0C_FIFO_W 8
`define SP0C_FIFO_D 16

`endif

// ==== sp0c_fifo.v ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes a power-of-two depth and a single clock.
`timescale 1ns/1ps
`default_nettype none
module sp0c_fifo #(
   parameter W = 8,
   parameter D = 16
)
(
   input wire mclk,
   input wire rst,
   input wire [W-1:0] in_data,
   input wire in_valid,
   output reg in_ready_r,
   output wire [W-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   localparam AW = $clog2(D);
   localparam [AW:0] FULL = D;
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0] cnt_r;
   reg [AW:0] cnt_nxt;
   wire push;
   wire pop;

   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data = mem[rp_r];
   assign push = in_valid && in_ready_r;
   assign pop = out_valid && out_ready;

   always @*
   begin
      cnt_nxt = cnt_r;
      if (push && !pop)
         cnt_nxt = cnt_r + 1'b1;
      else if (pop && !push)
         cnt_nxt = cnt_r - 1'b1;
   end

   always @(posedge mclk)
   begin
      if (push)
         mem[wp_r] <= in_data;
   end

   // Ready is registered so the source sees a clean flop output
   always @(posedge mclk)
   begin
      if (rst)
      begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
         in_ready_r <= 1'b0;
      end
      else
      begin
         if (push)
            wp_r <= wp_r + 1'b1;
         if (pop)
            rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_nxt;
         in_ready_r <= (cnt_nxt != FULL);
      end
   end
endmodule
`default_nettype wire

// ==== sp0c_peer.sv ====
// Remote serial node: sends frames on the line and samples frames.
// Assumes a 16x baud tick on mclk; line idles high.
`timescale 1ns/1ps
`default_nettype none
module sp0c_peer
(
   input wire logic mclk,
   input wire logic baud_tick,
   input wire logic txd,
   input wire logic m0_data,
   output logic rxd
);
   initial rxd = 1'b1;
   task automatic ticks(input int n);
      repeat (n) do @(posedge mclk); while (!baud_tick);
   endtask
   task automatic send(input logic nine, input logic [7:0] d,
      input logic b9, input logic stp);
      logic [10:0] f;
      f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
      for (int i = 0; i < 11; i++)
      begin
         rxd <= f[i];
         ticks(16);
      end
   endtask
   // Sample mid-bit; no tick after the last so back-to-back frames work
   task automatic recv(input int n, output logic [10:0] f);
      int w;
      w = 0;
      f = 11'h000;
      while (txd !== 1'b0 && w < 4000)
      begin
         @(posedge mclk);
         w++;
      end
      ticks(8);
      for (int i = 0; i < n; i++)
      begin
         f[i] = txd;
         if (i < n - 1)
            ticks(16);
      end
   endtask
   task automatic m0_recv(output logic [7:0] d);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge txd);
         d[i] = m0_data;
      end
   endtask
   // Mode 0 receive: next bit goes out on each falling shift clock
   task automatic m0_send(input logic [7:0] d);
      for (int i = 0; i < 8; i++)
      begin
         @(negedge txd);
         rxd <= d[i];
      end
      @(posedge txd);
      rxd <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== sp0c_shclk.v ====
// Half-period tick generator for the shift-register mode clock.
// Assumes run is held high for the whole shift sequence.
`timescale 1ns/1ps
`include "sp0c_defs.vh"
`default_nettype none
module sp0c_shclk
(
   input wire mclk,
   input wire rst,
   input wire run,
   input wire fast,
   output reg tick_r
);
   reg [2:0] cnt_r;
   wire [2:0] lim;

   // Two ticks make one shift clock period: /12 or /2 of mclk
   assign lim = fast ? `SP0C_HALF_FAST : `SP0C_HALF_STD;

   always @(posedge mclk)
   begin
      if (rst || !run)
      begin
         cnt_r <= 3'h0;
         tick_r <= 1'b0;
      end
      else if (cnt_r >= lim)
      begin
         cnt_r <= 3'h0;
         tick_r <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 3'h1;
         tick_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for sp0c_ctrl with a remote serial node.
// Assumes a baud tick every 4 mclk cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic mclk, rst, sfr_wr_en, sfr_rd_en, sfr_bit_wr_en, sfr_bit_wdata;
   logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, tx_data;
   logic [7:0] given_addr, broadcast_addr;
   logic frame_err_access_option, serial_int_enable, baud_tick, tx_valid;
   logic [1:0] bdiv;
   wire [7:0] sfr_rdata_r, rx_data_r;
   wire serial_irq_r, tx_ready, rx_valid_r, rxd_out_r, rxd_oe_r, txd_r;
   wire peer_rxd, rxd_in;
   int errors, samples_checked;
   assign rxd_in = rxd_oe_r ? rxd_out_r : peer_rxd;
   sp0c_ctrl u_sp0c_ctrl (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr),
      .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata), .sfr_rd_en(sfr_rd_en),
      .sfr_rdata_r(sfr_rdata_r), .sfr_bit_addr(sfr_bit_addr),
      .sfr_bit_wr_en(sfr_bit_wr_en), .sfr_bit_wdata(sfr_bit_wdata),
      .frame_err_access_option(frame_err_access_option),
      .serial_int_enable(serial_int_enable), .serial_irq_r(serial_irq_r),
      .baud_tick(baud_tick), .given_addr(given_addr),
      .broadcast_addr(broadcast_addr), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data_r(rx_data_r),
      .rx_valid_r(rx_valid_r), .rxd_in(rxd_in), .rxd_out_r(rxd_out_r),
      .rxd_oe_r(rxd_oe_r), .txd_r(txd_r));
   sp0c_peer u_sp0c_peer (.mclk(mclk), .baud_tick(baud_tick),
      .txd(txd_r), .m0_data(rxd_out_r), .rxd(peer_rxd));
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      bdiv <= bdiv + 2'h1;
      baud_tick <= (bdiv == 2'h3);
   end
   task automatic final_report();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr_en <= 1'b1;
      @(posedge mclk);
      sfr_wr_en <= 1'b0;
   endtask
   task automatic bwr(input logic [7:0] a, input logic b);
      @(posedge mclk);
      sfr_bit_addr <= a;
      sfr_bit_wdata <= b;
      sfr_bit_wr_en <= 1'b1;
      @(posedge mclk);
      sfr_bit_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_rd_en <= 1'b1;
      @(posedge mclk);
      sfr_rd_en <= 1'b0;
      #1 d = sfr_rdata_r;
   endtask
   task automatic push(input logic [7:0] d);
      @(posedge mclk);
      tx_data <= d;
      tx_valid <= 1'b1;
      do @(posedge mclk); while (!tx_ready);
      tx_valid <= 1'b0;
   endtask
   task automatic t_regs();
      logic [7:0] d;
      rd(8'h98, d);
      chk({3'h0, d}, 11'h000);
      wr(8'h98, 8'h58);
      rd(8'h98, d);
      chk({3'h0, d}, 11'h058);
      bwr(8'h9D, 1'b1);
      rd(8'h98, d);
      chk({3'h0, d}, 11'h078);
      rd(8'h9A, d);
      chk({3'h0, d}, 11'h000);
   endtask
   // Mode 1 fill until refused, then drain; stop bit where a ninth would be
   task automatic t_tx1();
      logic [10:0] f;
      logic [7:0] d;
      int n;
      n = 0;
      wr(8'h98, 8'h40);
      fork
         begin
            @(posedge mclk);
            tx_data <= 8'h10;
            tx_valid <= 1'b1;
            repeat (40)
            begin
               @(posedge mclk);
               if (tx_ready)
               begin
                  n++;
                  tx_data <= 8'h10 + n[7:0];
               end
            end
            tx_valid <= 1'b0;
            chk(11'(n), 11'd17);
         end
         for (int i = 0; i < 17; i++)
         begin
            u_sp0c_peer.recv(10, f);
            chk(f, {2'b01, 8'h10 + i[7:0], 1'b0});
         end
      join
      rd(8'h98, d);
      chk({3'h0, d}, 11'h042);
      @(posedge mclk);
      serial_int_enable <= 1'b0;
      repeat (3) @(posedge mclk);
      chk({10'h0, serial_irq_r}, 11'h000);
      serial_int_enable <= 1'b1;
      repeat (3) @(posedge mclk);
      chk({10'h0, serial_irq_r}, 11'h001);
      bwr(8'h99, 1'b0);
      repeat (3) @(posedge mclk);
      chk({10'h0, serial_irq_r}, 11'h000);
   endtask
   task automatic t_tx23();
      logic [10:0] f;
      for (int i = 0; i < 4; i++)
      begin
         // Let the running stop bit end before the mode changes
         repeat (40) @(posedge mclk);
         wr(8'h98, {1'b1, i[1], 2'b00, i[0], 3'b000});
         fork
            push(8'h3C);
            u_sp0c_peer.recv(11, f);
         join
         chk(f, {1'b1, i[0], 8'h3C, 1'b0});
      end
      repeat (40) @(posedge mclk);
   endtask
   task automatic t_m0();
      logic [7:0] d;
      for (int j = 0; j < 2; j++)
      begin
         wr(8'h98, {2'b00, j[0], 5'h00});
         fork
            push(8'hA5 ^ j[7:0]);
            u_sp0c_peer.m0_recv(d);
         join
         chk({3'h0, d}, {3'h0, 8'hA5 ^ j[7:0]});
         rd(8'h98, d);
         chk({3'h0, d}, {5'h00, j[0], 5'b00010});
      end
   endtask
   // Standard rate only: the pin synchroniser lags two cycles
   task automatic t_m0rx();
      logic [7:0] q;
      wr(8'h98, 8'h10);
      u_sp0c_peer.m0_send(8'h6B);
      repeat (2) @(posedge mclk);
      chk({3'h0, rx_data_r}, 11'h06B);
      rd(8'h98, q);
      chk({3'h0, q}, 11'h011);
   endtask
   task automatic rx_case(input logic [7:0] c, input logic nine,
      input logic [7:0] d, input logic b9, input logic stp, input logic acc);
      logic got;
      logic [7:0] r, q;
      got = 1'b0;
      r = 8'h00;
      wr(8'h98, c);
      fork
         u_sp0c_peer.send(nine, d, b9, stp);
         repeat (900)
         begin
            @(posedge mclk);
            if (rx_valid_r === 1'b1)
            begin
               got = 1'b1;
               r = rx_data_r;
            end
         end
      join
      rd(8'h98, q);
      chk({got, q[0], q[2], r},
         {acc, acc, acc & (nine ? b9 : stp), acc ? d : 8'h00});
   endtask
   task automatic t_rx();
      rx_case(8'h50, 0, 8'h96, 0, 1, 1);
      rx_case(8'h40, 0, 8'h96, 0, 1, 0);
      rx_case(8'h70, 0, 8'h21, 0, 1, 1);
      rx_case(8'h70, 0, 8'h21, 0, 0, 0);
      rx_case(8'h70, 0, 8'h55, 0, 1, 0);
      rx_case(8'h50, 0, 8'h33, 0, 0, 1);
      rx_case(8'hD0, 1, 8'h44, 0, 1, 1);
      rx_case(8'hF0, 1, 8'h21, 0, 1, 0);
      rx_case(8'hF0, 1, 8'hFF, 1, 1, 1);
      rx_case(8'hB0, 1, 8'h21, 1, 1, 1);
   endtask
   task automatic t_fe();
      logic [7:0] q;
      // Bit 7 no longer reaches the mode once the option is set
      wr(8'h98, 8'h50);
      @(posedge mclk);
      frame_err_access_option <= 1'b1;
      rx_case(8'h50, 0, 8'h33, 0, 0, 1);
      rd(8'h98, q);
      chk({10'h0, q[7]}, 11'h001);
      bwr(8'h9F, 1'b0);
      rd(8'h98, q);
      chk({10'h0, q[7]}, 11'h000);
   endtask
   initial
   begin
      rst = 1'b1;
      {sfr_wr_en, sfr_rd_en, sfr_bit_wr_en, sfr_bit_wdata} = 4'h0;
      {sfr_addr, sfr_wdata, sfr_bit_addr, tx_data} = 32'h0;
      {frame_err_access_option, baud_tick, tx_valid, bdiv} = 5'h00;
      serial_int_enable = 1'b1;
      given_addr = 8'h21;
      broadcast_addr = 8'hFF;
      errors = 0;
      samples_checked = 0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_tx1();
      t_tx23();
      t_m0();
      t_m0rx();
      t_rx();
      t_fe();
      final_report();
   end
   // Tests need about 24k cycles; this leaves ample margin
   initial
   begin
      #600000;
      errors++;
      final_report();
   end
endmodule
`default_nettype wire
